// ==== strap_cfg_defs.svh ====
// Offsets, field positions, reset values and timing counts of the strap loader.
// Assumes a 32-bit AXI4-Lite register window with byte addresses.
`ifndef STRAP_CFG_DEFS_SVH
`define STRAP_CFG_DEFS_SVH

`define OFS_PAUSE_CTRL   8'h00
`define OFS_ADVERTISE    8'h04
`define OFS_BASIC_CTRL   8'h08
`define OFS_SPEC_MODES   8'h0C
`define OFS_SPEC_CTRL    8'h10
`define OFS_STRAP_STAT   8'h14

`define BIT_PAUSE_SEL    0
`define BIT_PAUSE_TX     1
`define BIT_PAUSE_RX     2
`define BIT_ADV_PAUSE    10
`define BIT_ADV_100FD    8
`define BIT_ADV_100HD    7
`define BIT_ADV_10FD     6
`define BIT_ADV_10HD     5
`define BIT_BASIC_SPEED  13
`define BIT_BASIC_NEG    12
`define BIT_BASIC_DUPLEX 8
`define LSB_MODE         5
`define BIT_XO_OVERRIDE  15
`define BIT_XO_AUTO      14
`define BIT_XO_MDIX      13
`define BIT_XO_STATE     0

`define RST_PAUSE_TX     1'b1
`define RST_PAUSE_RX     1'b1
`define MODE_ALL_CAPABLE 3'h7
`define SETTLE_CYCLES    2'h3

`define RESP_OKAY        2'h0
`define RESP_DECERR      2'h3

`endif

// ==== strap_cfg_pkg.sv ====
// Types shared by the strap loader.
// Assumes strap_cfg_defs.svh carries the numbers.
package strap_cfg_pkg;
	typedef enum logic [1:0] {
		ST_SETTLE,
		ST_LOAD,
		ST_RUN
	} load_state_t;
endpackage

// ==== strap_default_port_config.sv ====
// Strap sampling, port configuration defaults and their AXI4-Lite registers.
// Assumes strap pins are static around reset and partnerPause is on clk_sys.
`timescale 1ns/1ps
`include "strap_cfg_defs.svh"

module strap_default_port_config
	import strap_cfg_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Strap pins
	input  wire logic        port1PauseOverrideStrap,
	input  wire logic        autoCrossoverStrap2,
	input  wire logic        manualCrossoverStrap2,
	input  wire logic        negotiationStrap2,
	input  wire logic        speedStrap2,
	input  wire logic        duplexStrap2,
	// Port logic
	input  wire logic        partnerPause,
	output logic             pauseTxActive,
	output logic             pauseRxActive,
	output logic             crossoverAuto,
	output logic             crossoverMdix,
	output logic             negotiationEnable,
	output logic             speedSelect,
	output logic             duplexSelect,
	output logic [2:0]       modeSelect,
	output logic             loadDone,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	load_state_t state_q;
	logic [1:0]  settle_q;
	logic [5:0]  strapMeta_q;
	logic [5:0]  strapSync_q;
	logic [5:0]  strapLatch_q;
	logic        pauseSel_q;
	logic        pauseTx_q;
	logic        pauseRx_q;
	logic        advPause_q;
	logic        adv100Fd_q;
	logic        adv100Hd_q;
	logic        adv10Fd_q;
	logic        adv10Hd_q;
	logic        negEn_q;
	logic        speed_q;
	logic        duplex_q;
	logic [2:0]  mode_q;
	logic        xoOverride_q;
	logic        xoAuto_q;
	logic        xoMdix_q;
	logic        awHeld_q;
	logic        wHeld_q;
	logic [7:0]  awAddr_q;
	logic [31:0] wData_q;
	logic [3:0]  wStrb_q;
	logic        wrFire;
	logic        sPause;
	logic        sAuto;
	logic        sMdix;
	logic        sNeg;
	logic        sSpeed;
	logic        sDuplex;

	// Byte-lane aware update of one register bit
	function automatic logic pick(input logic old, input int unsigned idx);
		return wStrb_q[idx / 8] ? wData_q[idx] : old;
	endfunction

	function automatic logic hit(input logic [7:0] ofs);
		return wrFire && (awAddr_q == ofs);
	endfunction

	assign {sPause, sAuto, sMdix, sNeg, sSpeed, sDuplex} = strapLatch_q;
	assign wrFire = awHeld_q && wHeld_q && !s_axi_bvalid;

	// Pins come from outside the clock domain
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			strapMeta_q <= 6'h00;
			strapSync_q <= 6'h00;
		end else begin
			strapMeta_q <= {port1PauseOverrideStrap, autoCrossoverStrap2,
				manualCrossoverStrap2, negotiationStrap2, speedStrap2, duplexStrap2};
			strapSync_q <= strapMeta_q;
		end
	end

	// Wait until the synchroniser holds real pin levels, then sample once
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q  <= ST_SETTLE;
			settle_q <= 2'h0;
			loadDone <= 1'b0;
		end else begin
			case (state_q)
				ST_SETTLE: begin
					settle_q <= settle_q + 2'h1;
					if (settle_q == `SETTLE_CYCLES)
						state_q <= ST_LOAD;
				end
				ST_LOAD: begin
					state_q  <= ST_RUN;
					loadDone <= 1'b1;
				end
				default: state_q <= ST_RUN;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst)
			strapLatch_q <= 6'h00;
		else if (state_q == ST_SETTLE && settle_q == `SETTLE_CYCLES)
			strapLatch_q <= strapSync_q;
	end

	// Defaults loaded from the latched straps, except pauseTx_q and pauseRx_q, then owned by software
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pauseSel_q <= 1'b0;
			pauseTx_q  <= `RST_PAUSE_TX;
			pauseRx_q  <= `RST_PAUSE_RX;
			advPause_q <= 1'b1;
			adv100Fd_q <= 1'b1;
			adv100Hd_q <= 1'b1;
			adv10Fd_q  <= 1'b1;
			adv10Hd_q  <= 1'b1;
			negEn_q    <= 1'b1;
			speed_q    <= 1'b1;
			duplex_q   <= 1'b1;
			mode_q     <= `MODE_ALL_CAPABLE;
		end else if (state_q == ST_LOAD) begin
			pauseSel_q <= sPause;
			advPause_q <= !sPause;
			negEn_q    <= sNeg;
			speed_q    <= sSpeed | sNeg;
			duplex_q   <= sDuplex | sNeg;
			adv10Fd_q  <= sNeg | (!sSpeed & sDuplex);
			adv10Hd_q  <= sNeg | (!sSpeed & !sDuplex);
			adv100Fd_q <= sNeg | (sSpeed & sDuplex);
			adv100Hd_q <= sNeg | (sSpeed & !sDuplex);
			mode_q     <= sNeg ? `MODE_ALL_CAPABLE : {1'b0, sSpeed, sDuplex};
		end else begin
			if (hit(`OFS_PAUSE_CTRL)) begin
				pauseSel_q <= pick(pauseSel_q, `BIT_PAUSE_SEL);
				pauseTx_q  <= pick(pauseTx_q, `BIT_PAUSE_TX);
				pauseRx_q  <= pick(pauseRx_q, `BIT_PAUSE_RX);
			end
			if (hit(`OFS_ADVERTISE)) begin
				advPause_q <= pick(advPause_q, `BIT_ADV_PAUSE);
				adv100Fd_q <= pick(adv100Fd_q, `BIT_ADV_100FD);
				adv100Hd_q <= pick(adv100Hd_q, `BIT_ADV_100HD);
				adv10Fd_q  <= pick(adv10Fd_q, `BIT_ADV_10FD);
				adv10Hd_q  <= pick(adv10Hd_q, `BIT_ADV_10HD);
			end
			if (hit(`OFS_BASIC_CTRL)) begin
				speed_q  <= pick(speed_q, `BIT_BASIC_SPEED);
				negEn_q  <= pick(negEn_q, `BIT_BASIC_NEG);
				duplex_q <= pick(duplex_q, `BIT_BASIC_DUPLEX);
			end
			if (hit(`OFS_SPEC_MODES)) begin
				mode_q <= {pick(mode_q[2], `LSB_MODE + 2), pick(mode_q[1], `LSB_MODE + 1),
					pick(mode_q[0], `LSB_MODE)};
			end
		end
	end

	// Crossover override fields have no strap of their own
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			xoOverride_q <= 1'b0;
			xoAuto_q     <= 1'b0;
			xoMdix_q     <= 1'b0;
		end else if (hit(`OFS_SPEC_CTRL)) begin
			xoOverride_q <= pick(xoOverride_q, `BIT_XO_OVERRIDE);
			xoAuto_q     <= pick(xoAuto_q, `BIT_XO_AUTO);
			xoMdix_q     <= pick(xoMdix_q, `BIT_XO_MDIX);
		end
	end

	// Effective port controls, registered so every output is a flop
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pauseTxActive     <= 1'b0;
			pauseRxActive     <= 1'b0;
			crossoverAuto     <= 1'b0;
			crossoverMdix     <= 1'b0;
			negotiationEnable <= 1'b0;
			speedSelect       <= 1'b0;
			duplexSelect      <= 1'b0;
			modeSelect        <= 3'h0;
		end else if (state_q == ST_RUN) begin
			if (pauseSel_q) begin
				pauseTxActive <= pauseTx_q;
				pauseRxActive <= pauseRx_q;
			end else begin
				// Pause only if both ends agreed during negotiation
				pauseTxActive <= negEn_q & advPause_q & partnerPause;
				pauseRxActive <= negEn_q & advPause_q & partnerPause;
			end
			if (xoOverride_q) begin
				crossoverAuto <= xoAuto_q;
				crossoverMdix <= xoMdix_q;
			end else begin
				crossoverAuto <= sAuto;
				crossoverMdix <= !sAuto & sMdix;
			end
			negotiationEnable <= negEn_q;
			speedSelect       <= speed_q;
			duplexSelect      <= duplex_q;
			modeSelect        <= mode_q;
		end
	end

	// Write channel: address and data taken in either order
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			awHeld_q      <= 1'b0;
			wHeld_q       <= 1'b0;
			awAddr_q      <= 8'h00;
			wData_q       <= 32'h0000_0000;
			wStrb_q       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			s_axi_awready <= (state_q == ST_RUN) && !awHeld_q && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= (state_q == ST_RUN) && !wHeld_q && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (wrFire) begin
				awHeld_q     <= 1'b0;
				wHeld_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awAddr_q <= `OFS_SPEC_CTRL && awAddr_q[1:0] == 2'h0) ?
					`RESP_OKAY : `RESP_DECERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel: answer one cycle after the address is taken
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			s_axi_arready <= (state_q == ST_RUN) && !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `RESP_OKAY;
				s_axi_rdata  <= 32'h0000_0000;
				if (s_axi_araddr == `OFS_PAUSE_CTRL) begin
					s_axi_rdata[`BIT_PAUSE_SEL] <= pauseSel_q;
					s_axi_rdata[`BIT_PAUSE_TX]  <= pauseTx_q;
					s_axi_rdata[`BIT_PAUSE_RX]  <= pauseRx_q;
				end else if (s_axi_araddr == `OFS_ADVERTISE) begin
					s_axi_rdata[`BIT_ADV_PAUSE] <= advPause_q;
					s_axi_rdata[`BIT_ADV_100FD] <= adv100Fd_q;
					s_axi_rdata[`BIT_ADV_100HD] <= adv100Hd_q;
					s_axi_rdata[`BIT_ADV_10FD]  <= adv10Fd_q;
					s_axi_rdata[`BIT_ADV_10HD]  <= adv10Hd_q;
				end else if (s_axi_araddr == `OFS_BASIC_CTRL) begin
					s_axi_rdata[`BIT_BASIC_SPEED]  <= speed_q;
					s_axi_rdata[`BIT_BASIC_NEG]    <= negEn_q;
					s_axi_rdata[`BIT_BASIC_DUPLEX] <= duplex_q;
				end else if (s_axi_araddr == `OFS_SPEC_MODES) begin
					s_axi_rdata[`LSB_MODE + 2 -: 3] <= mode_q;
				end else if (s_axi_araddr == `OFS_SPEC_CTRL) begin
					s_axi_rdata[`BIT_XO_OVERRIDE] <= xoOverride_q;
					s_axi_rdata[`BIT_XO_AUTO]     <= xoAuto_q;
					s_axi_rdata[`BIT_XO_MDIX]     <= xoMdix_q;
					s_axi_rdata[`BIT_XO_STATE]    <= crossoverAuto;
				end else if (s_axi_araddr == `OFS_STRAP_STAT) begin
					s_axi_rdata[5:0] <= strapLatch_q;
					s_axi_rdata[8]   <= loadDone;
				end else begin
					s_axi_rresp <= `RESP_DECERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	property p_adv_pause;
		@(posedge clk_sys) disable iff (rst)
		(state_q == ST_LOAD) |=> (advPause_q == !sPause);
	endproperty
	a_adv_pause: assert property (p_adv_pause) else $error("pause advert wrong");
	property p_sel_default;
		@(posedge clk_sys) disable iff (rst)
		(state_q == ST_LOAD) |=> (pauseSel_q == sPause) ##1 (pauseSel_q == sPause);
	endproperty
	a_sel_default: assert property (p_sel_default) else $error("select default wrong");
	property p_manual_pause;
		@(posedge clk_sys) disable iff (rst)
		(state_q == ST_RUN && pauseSel_q) |=> (pauseTxActive == $past(pauseTx_q)
			&& pauseRxActive == $past(pauseRx_q));
	endproperty
	a_manual_pause: assert property (p_manual_pause) else $error("manual pause wrong");
	property p_auto_pause;
		@(posedge clk_sys) disable iff (rst)
		(state_q == ST_RUN && !pauseSel_q && !advPause_q) |=> !pauseTxActive;
	endproperty
	a_auto_pause: assert property (p_auto_pause) else $error("pause without advert");
	property p_xo_strap;
		@(posedge clk_sys) disable iff (rst)
		(state_q == ST_RUN && !xoOverride_q) |=> (crossoverAuto == sAuto)
			&& (crossoverMdix == (!sAuto && sMdix));
	endproperty
	a_xo_strap: assert property (p_xo_strap) else $error("crossover strap ignored");
	property p_xo_override;
		@(posedge clk_sys) disable iff (rst)
		(state_q == ST_RUN && xoOverride_q) |=> (crossoverAuto == $past(xoAuto_q));
	endproperty
	a_xo_override: assert property (p_xo_override) else $error("override not honoured");
	property p_neg_default;
		@(posedge clk_sys) disable iff (rst)
		(state_q == ST_LOAD) |=> (negEn_q == sNeg) && (speed_q == (sSpeed || sNeg))
			&& (duplex_q == (sDuplex || sNeg));
	endproperty
	a_neg_default: assert property (p_neg_default) else $error("basic defaults wrong");
	property p_adv10;
		@(posedge clk_sys) disable iff (rst)
		(state_q == ST_LOAD && !sNeg) |=> (adv10Fd_q == (!sSpeed && sDuplex))
			&& (mode_q == {1'b0, sSpeed, sDuplex});
	endproperty
	a_adv10: assert property (p_adv10) else $error("10BASE-T defaults wrong");
	property p_hold;
		@(posedge clk_sys) disable iff (rst)
		(state_q == ST_RUN && !wrFire) |=> $stable(pauseSel_q) && $stable(mode_q)
			&& $stable(strapLatch_q);
	endproperty
	a_hold: assert property (p_hold) else $error("default changed unwritten");
endmodule

// ==== strap_board_model.sv ====
// Board-level strap settings seen by the strap loader at reset.
// Assumes the bench holds strapSet steady around every reset release.
`timescale 1ns/1ps

module strap_board_model (
	// Board settings, {pause, auto, mdix, neg, speed, duplex}
	input  wire logic [5:0] strapSet,
	input  wire logic       pauseAgree,
	// Strap pins and link partner
	output logic            pauseStrap,
	output logic            autoStrap,
	output logic            mdixStrap,
	output logic            negStrap,
	output logic            speedStrap,
	output logic            duplexStrap,
	output logic            partnerPause
);
	// Resistor straps are static; a later change must not reach the defaults
	assign {pauseStrap, autoStrap, mdixStrap} = strapSet[5:3];
	assign {negStrap, speedStrap, duplexStrap} = strapSet[2:0];
	assign partnerPause = pauseAgree;
endmodule

// ==== tb_strap_default_port_config.sv ====
// Self-checking bench: strap sets through reset, register reads and writes.
// Assumes the loader's AXI4-Lite slave and strap_board_model.
`timescale 1ns/1ps
`include "strap_cfg_defs.svh"

module tb_strap_default_port_config;
	logic        clk_sys = 1'h0, rst = 1'h1, pauseAgree = 1'h1;
	logic [5:0]  strapSet = 6'h00;
	logic        pauseStrap, autoStrap, mdixStrap, negStrap, speedStrap, duplexStrap;
	logic        partnerPause, pauseTxActive, pauseRxActive, crossoverAuto, crossoverMdix;
	logic        negotiationEnable, speedSelect, duplexSelect, loadDone;
	logic [2:0]  modeSelect;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [31:0] d;
	int          fails = 0, nTests = 0;

	always #2.5 clk_sys = ~clk_sys;

	strap_board_model strap_board_model_i (.strapSet(strapSet), .pauseAgree(pauseAgree),
		.pauseStrap(pauseStrap), .autoStrap(autoStrap), .mdixStrap(mdixStrap),
		.negStrap(negStrap), .speedStrap(speedStrap), .duplexStrap(duplexStrap),
		.partnerPause(partnerPause));

	strap_default_port_config strap_default_port_config_i (.clk_sys(clk_sys), .rst(rst),
		.port1PauseOverrideStrap(pauseStrap), .autoCrossoverStrap2(autoStrap),
		.manualCrossoverStrap2(mdixStrap), .negotiationStrap2(negStrap),
		.speedStrap2(speedStrap), .duplexStrap2(duplexStrap), .partnerPause(partnerPause),
		.pauseTxActive(pauseTxActive), .pauseRxActive(pauseRxActive),
		.crossoverAuto(crossoverAuto), .crossoverMdix(crossoverMdix),
		.negotiationEnable(negotiationEnable), .speedSelect(speedSelect),
		.duplexSelect(duplexSelect), .modeSelect(modeSelect), .loadDone(loadDone),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

	task automatic testDone;
		$display("Comparisons %0d, mismatches %0d", nTests, fails);
		if (fails == 0 && nTests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string w);
		nTests++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, w, got, exp);
		end
	endtask

	task automatic check_pin(input logic got, input logic exp, input string w);
		check_word({31'h0, got}, {31'h0, exp}, w);
	endtask

	// Handshakes are judged at the falling edge; payload is steady until the next rise
	task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rsp);
		logic awT, wT, bT;
		int   n;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		bT = 1'h0;
		n = 0;
		rsp = 2'h1;
		while (!bT && n < 50) begin
			@(negedge clk_sys);
			awT = s_axi_awvalid && s_axi_awready;
			wT = s_axi_wvalid && s_axi_wready;
			bT = s_axi_bvalid && s_axi_bready;
			if (bT) rsp = s_axi_bresp;
			@(posedge clk_sys);
			if (awT) s_axi_awvalid <= 1'h0;
			if (wT) s_axi_wvalid <= 1'h0;
			if (bT) s_axi_bready <= 1'h0;
			n++;
		end
		check_pin(bT, 1'h1, "write answered");
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rsp);
		logic arT, rT;
		int   n;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		rT = 1'h0;
		n = 0;
		v = 32'h0;
		rsp = 2'h1;
		while (!rT && n < 50) begin
			@(negedge clk_sys);
			arT = s_axi_arvalid && s_axi_arready;
			rT = s_axi_rvalid && s_axi_rready;
			if (rT) v = s_axi_rdata;
			if (rT) rsp = s_axi_rresp;
			@(posedge clk_sys);
			if (arT) s_axi_arvalid <= 1'h0;
			if (rT) s_axi_rready <= 1'h0;
			n++;
		end
		check_pin(rT, 1'h1, "read answered");
	endtask

	task automatic apply_reset(input logic [5:0] s);
		int n;
		@(posedge clk_sys);
		strapSet <= s;
		pauseAgree <= 1'h1;
		rst <= 1'h1;
		repeat (10) @(posedge clk_sys);
		rst <= 1'h0;
		n = 0;
		while (loadDone !== 1'h1 && n < 40) begin
			@(negedge clk_sys);
			n++;
		end
		check_pin(loadDone, 1'h1, "load finished");
		repeat (3) @(posedge clk_sys);
	endtask

	// Strap bits {pause, auto, mdix, neg, speed, duplex}
	task automatic run_set(input logic [5:0] s);
		logic       neg, spd, dup;
		logic [3:0] a4;
		logic [2:0] m;
		apply_reset(s);
		neg = s[2];
		spd = neg | s[1];
		dup = neg | s[0];
		a4 = neg ? 4'hF : {spd & dup, spd & !dup, !spd & dup, !spd & !dup};
		m = neg ? 3'h7 : {1'h0, s[1], s[0]};
		axi_read(`OFS_PAUSE_CTRL, d, r);
		check_word(d, {29'h0, 2'h3, s[5]}, "pause ctrl");
		axi_read(`OFS_ADVERTISE, d, r);
		check_word(d, {21'h0, !s[5], 1'h0, a4, 5'h0}, "advertisement");
		axi_read(`OFS_BASIC_CTRL, d, r);
		check_word(d, {18'h0, spd, neg, 3'h0, dup, 8'h0}, "basic ctrl");
		axi_read(`OFS_SPEC_MODES, d, r);
		check_word(d, {24'h0, m, 5'h0}, "special modes");
		axi_read(`OFS_SPEC_CTRL, d, r);
		check_pin(d[0], s[4], "effective crossover");
		axi_read(`OFS_STRAP_STAT, d, r);
		check_word(d, {23'h0, 1'h1, 2'h0, s}, "strap status");
		check_pin(crossoverAuto, s[4], "crossover auto");
		check_pin(crossoverMdix, !s[4] & s[3], "crossover fixed");
		check_pin(negotiationEnable, neg, "negotiation");
		check_pin(speedSelect, spd, "speed");
		check_pin(duplexSelect, dup, "duplex");
		check_word({29'h0, modeSelect}, {29'h0, m}, "mode pins");
		check_pin(pauseTxActive, s[5] | neg, "pause tx");
		check_pin(pauseRxActive, s[5] | neg, "pause rx");
		$display("test strap set %h done", s);
	endtask

	initial begin
		run_set(6'h29);
		run_set(6'h22);
		run_set(6'h00);
		run_set(6'h17);
		// Partner withdraws pause while negotiation decides
		pauseAgree <= 1'h0;
		repeat (2) @(posedge clk_sys);
		check_pin(pauseTxActive, 1'h0, "negotiated tx off");
		check_pin(pauseRxActive, 1'h0, "negotiated rx off");
		strapSet <= 6'h28;
		repeat (6) @(posedge clk_sys);
		axi_read(`OFS_BASIC_CTRL, d, r);
		check_word(d, 32'h3100, "held basic ctrl");
		check_pin(crossoverAuto, 1'h1, "held crossover");
		$display("test hold and negotiate done");
		// Partner agrees again, then software withdraws the pause advertisement
		pauseAgree <= 1'h1;
		repeat (2) @(posedge clk_sys);
		check_pin(pauseTxActive, 1'h1, "negotiated tx on");
		axi_write(`OFS_ADVERTISE, 32'h1E0, r);
		check_word({30'h0, r}, {30'h0, `RESP_OKAY}, "advert write resp");
		repeat (2) @(posedge clk_sys);
		check_pin(pauseTxActive, 1'h0, "unadvertised tx off");
		check_pin(pauseRxActive, 1'h0, "unadvertised rx off");
		axi_read(`OFS_ADVERTISE, d, r);
		check_word(d, 32'h1E0, "written advert");
		axi_write(`OFS_PAUSE_CTRL, 32'h5, r);
		repeat (2) @(posedge clk_sys);
		check_pin(pauseTxActive, 1'h0, "manual tx off");
		check_pin(pauseRxActive, 1'h1, "manual rx on");
		axi_write(`OFS_SPEC_CTRL, 32'hA000, r);
		repeat (2) @(posedge clk_sys);
		check_pin(crossoverAuto, 1'h0, "override auto");
		check_pin(crossoverMdix, 1'h1, "override mdix");
		axi_write(`OFS_BASIC_CTRL, 32'h0, r);
		repeat (2) @(posedge clk_sys);
		check_pin(negotiationEnable, 1'h0, "written negotiation");
		check_pin(speedSelect, 1'h0, "written speed");
		check_pin(duplexSelect, 1'h0, "written duplex");
		axi_write(`OFS_SPEC_MODES, 32'h60, r);
		repeat (2) @(posedge clk_sys);
		check_word({29'h0, modeSelect}, 32'h3, "written mode");
		$display("test register writes done");
		axi_read(8'h40, d, r);
		check_word({30'h0, r}, {30'h0, `RESP_DECERR}, "unmapped read resp");
		check_word(d, 32'h0, "unmapped read data");
		axi_write(8'h40, 32'hFFFF, r);
		check_word({30'h0, r}, {30'h0, `RESP_DECERR}, "unmapped write resp");
		$display("test unmapped access done");
		testDone;
	end

	// About thirty times the expected run length
	initial begin
		#30000;
		fails++;
		testDone;
	end
endmodule
